// [imt_buf_if.sv]
interface imt_buf_if;
    logic       in_valid;
    logic       in_ready;
    logic [7:0] in_data;
    logic       out_valid;
    logic       out_ready;
    logic [7:0] out_data;

    modport producer (output in_valid, output in_data, input in_ready,
                      input out_valid, input out_data, output out_ready);
    modport buffer   (input in_valid, input in_data, output in_ready,
                      output out_valid, output out_data, input out_ready);
endinterface

// [imt_master_tx.sv]
`include "imt_params.svh"
module imt_master_tx
    import imt_pkg::*;
#(
    parameter int BAUD_CYCLES = `IMT_BAUD_CYCLES,
    parameter int HOLD_CYCLES = `IMT_HOLD_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic [7:0] tx_buffer_data,
    input  wire logic       tx_buffer_write,
    input  wire logic       start_request_bit,
    input  wire logic       stop_request_bit,
    input  wire logic       restart_request_bit,
    input  wire logic       int_flag_clear,
    input  wire logic       collision_clear,
    output logic            buffer_full_flag,
    output logic            ack_status_bit,
    output logic            serial_port_int_flag,
    output logic            write_collision_flag,
    output logic            busy,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe_n,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n
);

    // ------------------------------------------------------------------
    // Buffer between the write port and the shifter
    // ------------------------------------------------------------------
    imt_buf_if bufc ();

    imt_skid_buf #(
        .DEPTH (2)
    ) u_buf (
        .mclk (mclk),
        .nrst (nrst),
        .bus  (bufc.buffer)
    );

    imt_state_type state_reg, state_next;
    logic [15:0]   cnt_reg, cnt_next;
    logic [7:0]    shift_reg, shift_next;
    logic [3:0]    bit_reg, bit_next;
    logic          sda_rel_reg, sda_rel_next;
    logic          scl_rel_reg, scl_rel_next;
    logic          full_reg, full_next;
    logic          ack_reg, ack_next;
    logic          irq_reg, irq_next;
    logic          write_collision_flag_reg, write_collision_flag_next;
    logic          phase_reg, phase_next;
    logic          shifting;
    logic          tick;
    logic          accept;

    // A transfer is active from the take-over until the ninth clock ends.
    assign shifting = (state_reg == IMT_LOW) || (state_reg == IMT_HIGH)
                      || (state_reg == IMT_SETUP);
    assign tick     = (cnt_reg == 16'(BAUD_CYCLES - 1));

    // Writes are only offered to the buffer when no byte is shifting.
    assign bufc.in_valid  = tx_buffer_write && !shifting && !full_reg;
    assign bufc.in_data   = tx_buffer_data;
    assign accept         = bufc.out_valid && (state_reg == IMT_PARK);
    assign bufc.out_ready = accept;

    assign buffer_full_flag     = full_reg;
    assign ack_status_bit       = ack_reg;
    assign serial_port_int_flag = irq_reg;
    assign write_collision_flag = write_collision_flag_reg;
    assign busy                 = !(state_reg == IMT_IDLE
                                    || state_reg == IMT_PARK);
    // Open-drain pins only ever pull low; release means enable high.
    assign scl_out  = 1'b0;
    assign sda_out  = 1'b0;
    assign scl_oe_n = scl_rel_reg;
    assign sda_oe_n = sda_rel_reg;

    // ------------------------------------------------------------------
    // Bit engine next state
    // ------------------------------------------------------------------
    // The counter measures baud periods; its HOLD_CYCLES compare delays the
    // SDA change after each SCL fall so data never moves under SCL high.
    always_comb begin
        state_next   = state_reg;
        cnt_next     = tick ? 16'h0 : cnt_reg + 16'h1;
        shift_next   = shift_reg;
        bit_next     = bit_reg;
        sda_rel_next = sda_rel_reg;
        scl_rel_next = scl_rel_reg;
        phase_next   = phase_reg;
        full_next    = full_reg;
        ack_next     = ack_reg;
        irq_next     = irq_reg;
        write_collision_flag_next    = write_collision_flag_reg;
        // Sticky flags: a hardware set in the clear cycle still wins.
        if (int_flag_clear) begin
            irq_next = 1'b0;
        end
        if (collision_clear) begin
            write_collision_flag_next = 1'b0;
        end
        if (tx_buffer_write && (shifting || full_reg)) begin
            write_collision_flag_next = 1'b1;
        end
        if (bufc.in_valid && bufc.in_ready) begin
            full_next = 1'b1;
        end
        case (state_reg)
            IMT_IDLE: begin
                cnt_next     = 16'h0;
                scl_rel_next = 1'b1;
                sda_rel_next = 1'b1;
                if (start_request_bit) begin
                    state_next = IMT_START;
                end
            end
            IMT_START: begin
                // SDA falls with SCL high, then SCL falls a period later.
                sda_rel_next = 1'b0;
                if (tick) begin
                    scl_rel_next = 1'b0;
                    irq_next     = 1'b1;
                    state_next   = IMT_PARK;
                end
            end
            IMT_PARK: begin
                cnt_next     = 16'h0;
                scl_rel_next = 1'b0;
                if (accept) begin
                    shift_next = bufc.out_data;
                    bit_next   = 4'h0;
                    state_next = IMT_SETUP;
                end else if (stop_request_bit) begin
                    sda_rel_next = 1'b0;
                    phase_next   = 1'b0;
                    state_next   = IMT_STOP;
                end else if (restart_request_bit) begin
                    sda_rel_next = 1'b1;
                    phase_next   = 1'b0;
                    state_next   = IMT_RESTART;
                end
            end
            IMT_SETUP: begin
                // Data changes a hold time after the SCL fall.
                if (cnt_reg == 16'(HOLD_CYCLES)) begin
                    sda_rel_next = (bit_reg == 4'h8) ? 1'b1
                                   : shift_reg[7];
                end
                if (tick) begin
                    scl_rel_next = 1'b1;
                    state_next   = IMT_HIGH;
                end else begin
                    state_next = IMT_SETUP;
                end
            end
            IMT_HIGH: begin
                // Clock stretching: the period starts once SCL reads high.
                if (!scl_in) begin
                    cnt_next = 16'h0;
                end else if (tick) begin
                    scl_rel_next = 1'b0;
                    if (bit_reg == 4'h8) begin
                        ack_next   = sda_in;
                        irq_next   = 1'b1;
                        state_next = IMT_PARK;
                    end else begin
                        shift_next = {shift_reg[6:0], 1'b0};
                        bit_next   = bit_reg + 4'h1;
                        if (bit_reg == 4'(`IMT_BITS_PER_BYTE - 1)) begin
                            full_next = 1'b0;
                        end
                        state_next = IMT_SETUP;
                    end
                end
            end
            IMT_STOP: begin
                // SCL released, then SDA released while SCL is high.
                if (tick) begin
                    if (!phase_reg) begin
                        scl_rel_next = 1'b1;
                        phase_next   = 1'b1;
                    end else begin
                        sda_rel_next = 1'b1;
                        irq_next     = 1'b1;
                        state_next   = IMT_IDLE;
                    end
                end
            end
            IMT_RESTART: begin
                // SDA high, SCL high, then SDA falls: a repeated Start.
                if (tick) begin
                    if (!phase_reg) begin
                        scl_rel_next = 1'b1;
                        phase_next   = 1'b1;
                    end else begin
                        state_next = IMT_START;
                    end
                end
            end
            default: begin
                state_next = IMT_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg   <= IMT_IDLE;
            cnt_reg     <= 16'h0;
            shift_reg   <= `IMT_BUF_RESET;
            bit_reg     <= 4'h0;
            sda_rel_reg <= 1'b1;
            scl_rel_reg <= 1'b1;
            phase_reg   <= 1'b0;
            full_reg    <= 1'b0;
            ack_reg     <= `IMT_ACK_RESET;
            irq_reg     <= 1'b0;
            write_collision_flag_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            shift_reg   <= shift_next;
            bit_reg     <= bit_next;
            sda_rel_reg <= sda_rel_next;
            scl_rel_reg <= scl_rel_next;
            phase_reg   <= phase_next;
            full_reg    <= full_next;
            ack_reg     <= ack_next;
            irq_reg     <= irq_next;
            write_collision_flag_reg    <= write_collision_flag_next;
        end
    end
endmodule

// [imt_master_tx_sva.sv]
// ----------------------------------------------------------------------
// Port checker for the master transmit block
// ----------------------------------------------------------------------
module imt_master_tx_sva #(
    parameter int BAUD_CYCLES = 8,
    parameter int HOLD_CYCLES = 2
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic tx_buffer_write,
    input wire logic start_request_bit,
    input wire logic stop_request_bit,
    input wire logic restart_request_bit,
    input wire logic int_flag_clear,
    input wire logic buffer_full_flag,
    input wire logic ack_status_bit,
    input wire logic serial_port_int_flag,
    input wire logic write_collision_flag,
    input wire logic busy,
    input wire logic scl_in,
    input wire logic scl_oe_n,
    input wire logic sda_oe_n
);
    // The data line moves a hold time after the clock falls, and is seen
    // one cycle after the hold count is reached.
    localparam int HW = HOLD_CYCLES + 1;
    logic [15:0] hi_cnt_reg;
    logic [15:0] lo_cnt_reg;

    // Phase lengths; the high count waits for the line itself, so a
    // stretching slave does not count against the master.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hi_cnt_reg <= 16'h0000;
            lo_cnt_reg <= 16'h0000;
        end else begin
            hi_cnt_reg <= (scl_oe_n && scl_in && busy)
                          ? hi_cnt_reg + 16'h1 : 16'h0;
            lo_cnt_reg <= (!scl_oe_n && busy) ? lo_cnt_reg + 16'h1 : 16'h0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Data must not move for the hold time after a falling clock.
    sequence s_hold;
        $stable(sda_oe_n) [*2];
    endsequence

    AST_FULL_ON_WRITE: assert property (
        tx_buffer_write && !busy && !buffer_full_flag |=> buffer_full_flag)
        else $error("full flag not set by write");
    AST_WRITE_COLLISION_FLAG_SET: assert property (
        tx_buffer_write && (busy || buffer_full_flag) |=> write_collision_flag)
        else $error("collision flag not set");
    AST_INT_HOLD: assert property (
        serial_port_int_flag && !int_flag_clear |=> serial_port_int_flag)
        else $error("interrupt flag dropped by itself");
    AST_ACK_AT_NINTH: assert property (
        !$stable(ack_status_bit) |-> ##[0:HW] serial_port_int_flag)
        else $error("ack status moved outside ninth clock");
    AST_SCL_LOW_TIME: assert property (
        $rose(scl_oe_n) && buffer_full_flag |-> lo_cnt_reg inside
        {[BAUD_CYCLES - 1:BAUD_CYCLES + HOLD_CYCLES + 1]})
        else $error("clock low time wrong");
    AST_SCL_HIGH_TIME: assert property (
        $fell(scl_oe_n) && $past(buffer_full_flag) |-> hi_cnt_reg inside
        {[BAUD_CYCLES - 1:BAUD_CYCLES + 1]})
        else $error("clock high time wrong");
    AST_SDA_HOLD: assert property (
        $fell(scl_oe_n) && buffer_full_flag |-> s_hold)
        else $error("data moved within hold time");
    AST_SDA_FREE_8TH: assert property (
        $fell(buffer_full_flag) |-> ##[0:HW] sda_oe_n)
        else $error("data line not released after eighth bit");
    AST_PARK: assert property (
        !busy && !scl_oe_n && !tx_buffer_write && !stop_request_bit
        && !restart_request_bit |=> !scl_oe_n && $stable(sda_oe_n))
        else $error("parked bus moved");
    AST_START: assert property (
        start_request_bit && !busy && scl_oe_n |-> ##[1:2] !sda_oe_n)
        else $error("start request gave no start");
endmodule

bind imt_master_tx imt_master_tx_sva #(
    .BAUD_CYCLES(BAUD_CYCLES),
    .HOLD_CYCLES(HOLD_CYCLES)
) sva_u (.mclk, .nrst, .tx_buffer_write, .start_request_bit,
    .stop_request_bit, .restart_request_bit, .int_flag_clear,
    .buffer_full_flag, .ack_status_bit, .serial_port_int_flag,
    .write_collision_flag, .busy, .scl_in, .scl_oe_n, .sda_oe_n);

// [imt_params.svh]
`ifndef IMT_PARAMS_SVH
`define IMT_PARAMS_SVH

// ----------------------------------------------------------------------
// Timing and reset constants
// ----------------------------------------------------------------------
`define IMT_CLK_MHZ        100
`define IMT_BAUD_NS        5000
`define IMT_BAUD_CYCLES    ((`IMT_BAUD_NS * `IMT_CLK_MHZ) / 1000)
`define IMT_HOLD_NS        300
`define IMT_HOLD_CYCLES    (((`IMT_HOLD_NS * `IMT_CLK_MHZ) + 999) / 1000)
`define IMT_BITS_PER_BYTE  8
`define IMT_ACK_RESET      1'b0
`define IMT_BUF_RESET      8'h00

`endif

// [imt_pkg.sv]
package imt_pkg;

    // ------------------------------------------------------------------
    // Transfer engine states
    // ------------------------------------------------------------------
    typedef enum logic [7:0] {
        IMT_IDLE    = 8'h01,
        IMT_START   = 8'h02,
        IMT_LOW     = 8'h04,
        IMT_HIGH    = 8'h08,
        IMT_PARK    = 8'h10,
        IMT_STOP    = 8'h20,
        IMT_RESTART = 8'h40,
        IMT_SETUP   = 8'h80
    } imt_state_type;

endpackage

// [imt_skid_buf.sv]
// ----------------------------------------------------------------------
// Two-entry buffer between the software write port and the shifter
// ----------------------------------------------------------------------
module imt_skid_buf #(
    parameter int DEPTH = 2
) (
    input wire logic  mclk,
    input wire logic  nrst,
    imt_buf_if.buffer bus
);
    logic [7:0] mem_reg [DEPTH];
    logic [1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [1:0] cnt_reg, cnt_next;
    logic       push, pop;

    assign bus.in_ready  = (cnt_reg != 2'(DEPTH));
    assign bus.out_valid = (cnt_reg != 2'h0);
    assign bus.out_data  = mem_reg[rd_reg[0]];
    assign push          = bus.in_valid && bus.in_ready;
    assign pop           = bus.out_valid && bus.out_ready;

    // Pointer and occupancy update; full stalls the writer honestly.
    always_comb begin
        wr_next  = push ? wr_reg + 2'h1 : wr_reg;
        rd_next  = pop ? rd_reg + 2'h1 : rd_reg;
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_reg  <= 2'h0;
            rd_reg  <= 2'h0;
            cnt_reg <= 2'h0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage has no reset; only entries marked valid are ever read.
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_reg[wr_reg[0]] <= bus.in_data;
        end
    end
endmodule

// [imt_slave_model.sv]
// ----------------------------------------------------------------------
// Slave on the two-wire bus; no address match, every byte is acked per ack_en
// ----------------------------------------------------------------------
module imt_slave_model (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       ack_en,
    input  wire logic       stretch,
    output logic      [7:0] rx_byte,
    output logic            scl_oe_n,
    output logic            sda_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       scl_reg, sda_reg;
    logic [3:0] cnt_reg;
    logic [2:0] hold_reg;

    // Stretching holds the clock low a few cycles after each fall.
    assign scl_oe_n = (hold_reg == 3'h0);

    // Bits are taken on rising clock; a Start clears the bit count.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            {scl_reg, sda_reg, sda_oe_n} <= 3'h7;
            cnt_reg <= 4'h0;
            hold_reg <= 3'h0;
            rx_byte <= 8'h00;
        end else begin
            scl_reg <= scl;
            sda_reg <= sda;
            if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
            if (scl && scl_reg && sda_reg && !sda) begin
                cnt_reg <= 4'h0;
            end else if (scl && !scl_reg) begin
                cnt_reg <= cnt_reg + 4'h1;
                if (cnt_reg < 4'h8) rx_byte <= {rx_byte[6:0], sda};
            end else if (!scl && scl_reg) begin
                if (stretch) hold_reg <= 3'h5;
                if (cnt_reg == 4'h8) sda_oe_n <= !ack_en;
                if (cnt_reg == 4'h9) begin
                    sda_oe_n <= 1'b1;
                    cnt_reg <= 4'h0;
                end
            end
        end
    end
endmodule

// [testbench.sv]
// ----------------------------------------------------------------------
// Bench: software calls against the master and a slave model
// ----------------------------------------------------------------------
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [5:0] ST = 6'h20, SP = 6'h10, RS = 6'h08;
    localparam logic [5:0] WR = 6'h04, IC = 6'h02, CC = 6'h01;
    logic       mclk = 1'b0;
    logic       nrst = 1'b0;
    logic [5:0] ctl = 6'h00;
    logic [7:0] tx_buffer_data = 8'h00;
    logic       ack_en = 1'b1;
    logic       stretch = 1'b0;
    logic       buffer_full_flag, ack_status_bit, serial_port_int_flag;
    logic       write_collision_flag, busy, scl_oe_n, sda_oe_n;
    logic       s_scl_oe_n, s_sda_oe_n, scl, sda;
    logic [7:0] rx_byte;
    int         bad_count = 0;
    int         num_checks = 0;
    int         cyc = 0;

    // Open-drain lines with pull-ups: low if any party pulls.
    assign scl = scl_oe_n & s_scl_oe_n;
    assign sda = sda_oe_n & s_sda_oe_n;
    always #5 mclk = ~mclk;

    imt_master_tx #(.BAUD_CYCLES(8), .HOLD_CYCLES(2)) dut_u (
        .mclk, .nrst, .tx_buffer_data, .tx_buffer_write(ctl[2]),
        .start_request_bit(ctl[5]), .stop_request_bit(ctl[4]),
        .restart_request_bit(ctl[3]), .int_flag_clear(ctl[1]),
        .collision_clear(ctl[0]), .buffer_full_flag, .ack_status_bit,
        .serial_port_int_flag, .write_collision_flag, .busy,
        .scl_in(scl), .scl_out(), .scl_oe_n, .sda_in(sda), .sda_out(),
        .sda_oe_n);
    imt_slave_model slv_u (.mclk, .nrst, .scl, .sda, .ack_en, .stretch,
        .rx_byte, .scl_oe_n(s_scl_oe_n), .sda_oe_n(s_sda_oe_n));

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One-cycle software request, launched off the sampling edge.
    task automatic op(input logic [5:0] k, input logic [7:0] d);
        @(negedge mclk);
        ctl = k;
        tx_buffer_data = d;
        @(negedge mclk);
        ctl = 6'h00;
    endtask

    // Bounded wait for the flag, which must then stay until cleared.
    task automatic wait_int();
        repeat (2000) if (serial_port_int_flag !== 1'b1) @(negedge mclk);
        repeat (3) @(negedge mclk);
        chk("int_flag", serial_port_int_flag, 1'b1);
        op(IC, 8'h00);
    endtask

    // A stuck handshake would hang the run; the ceiling is far above
    // the several hundred cycles the sequence needs.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'b1;
        op(ST, 8'h00);
        wait_int();
        chk("sda_start", sda, 1'b0);
        $display("test start done");
        op(WR, 8'ha5);
        chk("full", buffer_full_flag, 1'b1);
        repeat (4) @(negedge mclk);
        op(WR, 8'h5a);
        chk("collision", write_collision_flag, 1'b1);
        chk("busy", busy, 1'b1);
        op(CC, 8'h00);
        chk("coll_clear", write_collision_flag, 1'b0);
        wait_int();
        chk("addr", rx_byte, 8'ha5);
        chk("ack", ack_status_bit, 1'b0);
        chk("full_off", buffer_full_flag, 1'b0);
        chk("scl_park", scl, 1'b0);
        chk("busy_park", busy, 1'b0);
        $display("test address done");
        ack_en = 1'b0;
        stretch = 1'b1;
        op(WR, 8'h3c);
        wait_int();
        chk("data", rx_byte, 8'h3c);
        chk("nack", ack_status_bit, 1'b1);
        $display("test data done");
        ack_en = 1'b1;
        stretch = 1'b0;
        op(RS, 8'h00);
        wait_int();
        op(WR, 8'h81);
        wait_int();
        chk("addr2", rx_byte, 8'h81);
        chk("ack2", ack_status_bit, 1'b0);
        op(SP, 8'h00);
        wait_int();
        chk("idle", {scl, sda}, 8'h03);
        $display("test restart_stop done");
        close_out();
    end
endmodule
